/* src/host_tx_fifo_config.sv */
// Configuration field, start decision and underrun detection of the host transmit path
`timescale 1ns/1ps
`default_nettype none
module host_tx_fifo_config
   import host_tx_fifo_config_pkg::*;
#(
   parameter int CNT_W = 12
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Configuration word access
   input wire logic cfg_wr,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   // Transmit queue state (dwords held, whole frame present, word popped)
   input wire logic [CNT_W-1:0] data_level,
   input wire logic frame_complete,
   input wire logic pop_frame_word,
   input wire logic frame_end_popped,
   input wire logic link_idle,
   // Outputs to the MAC and allocator
   output logic tx_start,
   output logic tx_active,
   output logic tx_underrun,
   output logic [15:0] status_fifo_bytes,
   output logic [15:0] data_fifo_bytes
);
   // Held configuration fields
   logic speed_mode_reg;
   logic store_fwd_reg;
   logic [3:0] size_reg;
   logic [1:0] thr_sel_reg;
   // Fields as presented with a write
   logic wr_speed_mode;
   logic wr_store_fwd;
   logic [3:0] wr_size;
   logic [1:0] wr_thr_sel;
   // Transmit progress
   logic active_reg;
   logic underrun_reg;
   // Allocation
   logic [3:0] size_eff;
   logic [15:0] alloc_bytes;
   // Start decision
   logic [8:0] thr_10m;
   logic [8:0] thr_100m;
   logic [8:0] thr_dw;
   logic [CNT_W-1:0] thr_level;
   logic level_reached;
   logic early_ok;
   logic start_ok;
   // Underrun detection
   logic queue_empty;
   logic starved;
   logic frame_done;

   // Only the owned fields are picked off; reserved bits never reach a flop
   always_comb begin
      wr_speed_mode = cfg_wdata[SPEED_MODE_BIT]; // RULE5
      wr_store_fwd = cfg_wdata[STORE_FWD_BIT];
      wr_size = cfg_wdata[SIZE_HI:SIZE_LO]; // RULE6
      wr_thr_sel = cfg_wdata[THR_SEL_HI:THR_SEL_LO]; // RULE9
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         speed_mode_reg <= 1'b0; // RULE5
      end else if (cfg_wr) begin
         speed_mode_reg <= wr_speed_mode; // RULE5
      end
   end

   // Gates every threshold field below
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         store_fwd_reg <= 1'b0;
      end else if (cfg_wr) begin
         store_fwd_reg <= wr_store_fwd; // RULE1
      end
   end

   // Kept as written; clamping happens on the way out
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         size_reg <= SIZE_RESET; // RULE6
      end else if (cfg_wr) begin
         size_reg <= wr_size; // RULE6
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         thr_sel_reg <= 2'b00; // RULE9
      end else if (cfg_wr) begin
         thr_sel_reg <= wr_thr_sel; // RULE9
      end
   end

   // Unowned bits read as zero
   always_comb begin
      cfg_rdata = 32'h0000_0000; // RULE11
      cfg_rdata[SPEED_MODE_BIT] = speed_mode_reg;
      cfg_rdata[STORE_FWD_BIT] = store_fwd_reg;
      cfg_rdata[SIZE_HI:SIZE_LO] = size_reg;
      cfg_rdata[THR_SEL_HI:THR_SEL_LO] = thr_sel_reg;
   end

   // Out-of-range sizes clamp so the allocator never sees less than 2 KB or over 14 KB
   always_comb begin
      if (size_reg < SIZE_MIN_KB) begin
         size_eff = SIZE_MIN_KB; // RULE7
      end else if (size_reg > SIZE_MAX_KB) begin
         size_eff = SIZE_MAX_KB; // RULE6
      end else begin
         size_eff = size_reg;
      end
   end

   // Whole kilobytes; the status share comes off the top
   always_comb begin
      alloc_bytes = {2'b00, size_eff, 10'h000}; // RULE6
   end

   // Commands and data share the one data allocation
   assign status_fifo_bytes = STATUS_FIFO_BYTES; // RULE7
   assign data_fifo_bytes = alloc_bytes - STATUS_FIFO_BYTES; // RULE7 RULE8

   // 10 Mbps table, indexed by the select field
   always_comb begin
      case (thr_sel_reg)
         2'b00: begin
            thr_10m = THR_10M_0; // RULE10
         end
         2'b01: begin
            thr_10m = THR_10M_1; // RULE10
         end
         2'b10: begin
            thr_10m = THR_10M_2; // RULE10
         end
         default: begin
            thr_10m = THR_10M_3; // RULE10
         end
      endcase
   end

   // 100M select codes other than 00 are undefined; they fall back to 020h
   always_comb begin
      thr_100m = THR_100M_0; // RULE10
   end

   // Speed mode picks the table; software keeps it clear at 100 Mbps
   always_comb begin
      if (speed_mode_reg) begin
         thr_dw = thr_10m; // RULE5 RULE9
      end else begin
         thr_dw = thr_100m; // RULE5
      end
   end

   // Resized to the level port so the compare happens in one width
   always_comb begin
      thr_level = CNT_W'(thr_dw);
   end

   // Early start once the threshold is buffered, or the frame is whole anyway
   always_comb begin
      level_reached = data_level >= thr_level; // RULE3
      early_ok = frame_complete || level_reached; // RULE3
   end

   // Store-and-forward waits for the whole frame; threshold fields play no part
   always_comb begin
      if (store_fwd_reg) begin
         start_ok = frame_complete; // RULE1 RULE2
      end else begin
         start_ok = early_ok; // RULE3
      end
   end

   // One-cycle pulse: active rises on the same edge and masks it
   always_comb begin
      if (!active_reg && link_idle) begin
         tx_start = start_ok; // RULE1 RULE3
      end else begin
         tx_start = 1'b0;
      end
   end

   assign tx_active = active_reg;
   assign tx_underrun = underrun_reg;

   // A frame ends on its last dword, or is abandoned on underrun
   always_comb begin
      frame_done = frame_end_popped || underrun_reg;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         active_reg <= 1'b0;
      end else if (tx_start) begin
         active_reg <= 1'b1;
      end else if (frame_done) begin
         active_reg <= 1'b0;
      end
   end

   // Pop wanted with no dword queued and frame tail not yet in
   always_comb begin
      queue_empty = data_level == '0;
      starved = active_reg && pop_frame_word && !frame_complete && queue_empty; // RULE4
   end

   // Set is blocked while the flag stands, so the error is one pulse per frame
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         underrun_reg <= 1'b0;
      end else begin
         underrun_reg <= starved && !underrun_reg; // RULE4
      end
   end
endmodule // host_tx_fifo_config
`default_nettype wire

/* src/host_tx_fifo_config_pkg.sv */
// Constants for the host transmit FIFO configuration block
// Function
// RULE1: With store-and-forward set, a whole frame is buffered before sending starts.
// RULE2: With store-and-forward set, speed-mode and threshold-select bits are ignored.
// RULE3: With store-and-forward clear, sending starts early at the threshold level.
// RULE4: Early start whose data runs dry before frame end flags a transmit underrun.
// RULE5: Speed-mode bit 21, read/write, resets 0; software keeps it 0 at 100 Mbps.
// RULE6: FIFO size field bits 19:16 sets allocation in 1 KB steps, max 14, reset 5.
// RULE7: Status FIFO takes 512 bytes, data FIFO the rest; combined minimum 2 KB.
// RULE8: Data FIFO carries command words and frame data interleaved in one queue.
// RULE9: Threshold-select bits 13:12, read/write, reset 00, set the start level.
// RULE10: Thresholds in dwords: 10M 012h/018h/020h/028h; 100M select 00 gives 020h.
// RULE11: Reserved bits 15:14 read as zero and ignore writes.
package host_tx_fifo_config_pkg;
   localparam int SPEED_MODE_BIT = 21;
   localparam int STORE_FWD_BIT = 20;
   localparam int SIZE_HI = 19;
   localparam int SIZE_LO = 16;
   localparam int THR_SEL_HI = 13;
   localparam int THR_SEL_LO = 12;
   localparam logic [3:0] SIZE_RESET = 4'h5;
   localparam logic [3:0] SIZE_MIN_KB = 4'h2;
   localparam logic [3:0] SIZE_MAX_KB = 4'hE;
   localparam logic [15:0] STATUS_FIFO_BYTES = 16'h0200;
   localparam logic [31:0] CFG_WRITE_MASK = 32'h003F_3000;
   localparam logic [8:0] THR_10M_0 = 9'h012;
   localparam logic [8:0] THR_10M_1 = 9'h018;
   localparam logic [8:0] THR_10M_2 = 9'h020;
   localparam logic [8:0] THR_10M_3 = 9'h028;
   localparam logic [8:0] THR_100M_0 = 9'h020;
endpackage

/* tb/host_feed_model.sv */
// Host side model filling the transmit queue one dword a cycle
`timescale 1ns/1ps
`default_nettype none
module host_feed_model (
   input wire logic clk_sys, sys_rst,
   input wire logic [11:0] len,
   output logic [11:0] data_level,
   output logic frame_complete);
   // Command and frame dwords share one count
   always_ff @(posedge clk_sys) begin
      data_level <= sys_rst ? 12'h000 : data_level < len ? data_level + 12'h001 : len;
   end
   assign frame_complete = data_level == len && len != 12'h000;
endmodule // host_feed_model
`default_nettype wire

/* tb/host_tx_fifo_config_bench.sv */
// Bench for the host transmit FIFO configuration block
`timescale 1ns/1ps
`default_nettype none
`define CK(n,e,a) begin check_count++; if ((a) !== (e)) begin mismatches++; \
   $display("wrong value %s exp %h got %h", n, e, a); end end
module host_tx_fifo_config_bench;
   import host_tx_fifo_config_pkg::*;
   logic clk_sys = 0, sys_rst = 1, cfg_wr = 0, pop = 0, fe = 0, idle = 1, fc, st, act, ur;
   logic [31:0] wd = 0, rd;
   logic [11:0] len = 0, lvl;
   logic [15:0] db, sb;
   int mismatches = 0, check_count = 0, cyc = 0;
   always #4 clk_sys = ~clk_sys;
   host_feed_model u_host_feed_model (.clk_sys, .sys_rst, .len, .data_level(lvl),
      .frame_complete(fc));
   host_tx_fifo_config u_host_tx_fifo_config (.clk_sys, .sys_rst, .cfg_wr,
      .cfg_wdata(wd), .cfg_rdata(rd), .data_level(lvl), .frame_complete(fc),
      .pop_frame_word(pop), .frame_end_popped(fe), .link_idle(idle), .tx_start(st),
      .tx_active(act), .tx_underrun(ur), .status_fifo_bytes(sb), .data_fifo_bytes(db));
   task automatic tick; @(posedge clk_sys); #1; endtask
   task automatic wr(input logic [31:0] d); cfg_wr = 1; wd = d; tick; cfg_wr = 0; tick; endtask
   task automatic frame(input logic [31:0] c, input logic [11:0] t);
      wr(c); len = 12'h030;
      repeat (60) if (!st) tick;
      `CK("level", t, lvl)
      tick; fe = 1; len = 0; tick; fe = 0; tick;
      `CK("end", 1'b0, act)
   endtask
   task automatic underrun;
      wr(32'h0); len = 12'h030;
      repeat (60) if (!st) tick;
      tick; len = 0; tick; pop = 1; tick; pop = 0;
      `CK("ur", 1'b1, ur)
      tick; `CK("ur act", 1'b0, act)
   endtask
   task automatic hold_off;
      wr(32'h00100000); idle = 0; len = 12'h030;
      repeat (50) tick;
      `CK("hold", 1'b0, st)
      idle = 1; #1;
      `CK("go", 1'b1, st)
      tick; fe = 1; len = 0; tick; fe = 0; tick;
      `CK("hold end", 1'b0, act)
   endtask
   task automatic finish_test;
      if (mismatches == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk_sys) if (++cyc > 3000) begin mismatches++; finish_test; end
   initial begin
      repeat (5) tick; sys_rst = 0;
      `CK("reset", 32'h00050000, rd)
      `CK("bytes", 16'h1200, db)
      `CK("status", 16'h0200, sb)
      wr(32'hFFFFFFFF); `CK("mask", CFG_WRITE_MASK, rd)
      `CK("hi", 16'h3600, db)
      wr(32'h00010000); `CK("lo", 16'h0600, db)
      frame(32'h00200000, 12'h012);
      frame(32'h00201000, 12'h018);
      frame(32'h00202000, 12'h020);
      frame(32'h00203000, 12'h028);
      frame(32'h00000000, 12'h020);
      frame(32'h00303000, 12'h030);
      frame(32'h00003000, 12'h020);
      hold_off;
      underrun;
      finish_test;
   end
endmodule // host_tx_fifo_config_bench
`default_nettype wire

/* tb/tx_cfg_properties.sv */
// Port checker for the host transmit FIFO configuration block
`timescale 1ns/1ps
`default_nettype none
module tx_cfg_properties #(parameter int CNT_W = 12) (
   input wire logic clk_sys, sys_rst, cfg_wr, frame_complete, link_idle,
   input wire logic tx_start, tx_active, tx_underrun,
   input wire logic [31:0] cfg_wdata, cfg_rdata,
   input wire logic [CNT_W-1:0] data_level,
   input wire logic [15:0] status_fifo_bytes, data_fifo_bytes);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   a_cfg_write_back: assert property (
      cfg_wr |=> cfg_rdata == ($past(cfg_wdata) & 32'h003F3000)) else $error("cfg");
   a_reserved_zero: assert property (
      (cfg_rdata & 32'hFFC0CFFF) == 32'h00000000) else $error("rsv");
   a_sf_whole_frame: assert property (
      tx_start && cfg_rdata[20] |-> frame_complete) else $error("sf");
   a_start_when_idle: assert property (
      tx_start |-> link_idle && !tx_active) else $error("idle");
   a_start_level: assert property (
      tx_start && !frame_complete |-> data_level >= 9'h012) else $error("lvl");
   a_start_active: assert property (
      tx_start |=> tx_active) else $error("act");
   a_underrun_end: assert property (
      tx_underrun |=> !tx_active && !tx_underrun) else $error("ur");
   a_status_size: assert property (
      status_fifo_bytes == 16'h0200) else $error("stat");
   a_data_size: assert property (
      data_fifo_bytes[9:0] == 10'h200 && data_fifo_bytes <= 16'h3600) else $error("data");
   cover property (tx_start && cfg_rdata[20]);
   cover property (tx_underrun);
   cover property (cfg_wr);
endmodule // tx_cfg_properties
bind host_tx_fifo_config tx_cfg_properties #(.CNT_W(CNT_W)) u_tx_cfg_properties (.*);
`default_nettype wire
